// File: interrupt_priority_fields.sv
// interrupt priority field registers with request gating
//
// Notes on behaviour
// [R1] code 111 gives the source priority level seven, the highest
// [R2] code 001 gives level one; other codes map to their own value
// [R3] code 000 disables the source; it never raises a request
// [R4] bits outside the priority fields read as zero
// [R5] first register: timer five level in bits 6..4, rest unused
// [R6] second register: collision level bits 10..8, event level bits 6..4
// [R7] every field resets to 100, level four, and is read/write
// [R8] writes to unused bits are ignored and change no field
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`include "interrupt_priority_fields_defines.svh"

module interrupt_priority_fields (
   input  wire logic                                   core_clk_i,
   input  wire logic                                   sys_rst_i,
   input  wire interrupt_priority_fields_pkg::addr_t   addr_i,
   input  wire interrupt_priority_fields_pkg::data_t   wdata_i,
   input  wire logic                                   wr_i,
   input  wire logic                                   rd_i,
   output interrupt_priority_fields_pkg::data_t        rdata_o,
   input  wire logic                                   capture_timer5_src_i,
   input  wire logic                                   serial2_collision_src_i,
   input  wire logic                                   serial2_event_src_i,
   output logic                                        capture_timer5_req_o,
   output interrupt_priority_fields_pkg::level_t       capture_timer5_req_level_o,
   output logic                                        serial2_collision_req_o,
   output interrupt_priority_fields_pkg::level_t       serial2_collision_req_level_o,
   output logic                                        serial2_event_req_o,
   output interrupt_priority_fields_pkg::level_t       serial2_event_req_level_o,
   output interrupt_priority_fields_pkg::level_t       capture_timer5_level_o,
   output interrupt_priority_fields_pkg::level_t       serial2_collision_level_o,
   output interrupt_priority_fields_pkg::level_t       serial2_event_level_o
);

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   interrupt_priority_fields_pkg::reg_sel_t sel;
   logic                                    wr_ct5;
   logic                                    wr_ser2;

   always_comb begin
      if (addr_i == `IPF_CT5_PRIO_ADDR) begin
         sel = interrupt_priority_fields_pkg::SEL_CT5;
      end else if (addr_i == `IPF_SER2_PRIO_ADDR) begin
         sel = interrupt_priority_fields_pkg::SEL_SER2;
      end else begin
         sel = interrupt_priority_fields_pkg::SEL_NONE;
      end
   end

   assign wr_ct5  = wr_i && (sel == interrupt_priority_fields_pkg::SEL_CT5);
   assign wr_ser2 = wr_i && (sel == interrupt_priority_fields_pkg::SEL_SER2);

   // ---------------------------------------------------------------
   // priority fields
   // ---------------------------------------------------------------
   interrupt_priority_fields_pkg::level_t capture_timer5_level;
   interrupt_priority_fields_pkg::level_t serial2_collision_level;
   interrupt_priority_fields_pkg::level_t serial2_event_level;

   // [R5] timer five field
   priority_field u_ct5 (
      .core_clk_i  (core_clk_i),
      .sys_rst_i   (sys_rst_i),
      .wr_en_i     (wr_ct5),
      .wdata_i     (wdata_i[`IPF_CT5_MSB:`IPF_CT5_LSB]),
      .src_i       (capture_timer5_src_i),
      .req_o       (capture_timer5_req_o),
      .req_level_o (capture_timer5_req_level_o),
      .level_o     (capture_timer5_level)
   );

   // [R6] collision field
   priority_field u_coll (
      .core_clk_i  (core_clk_i),
      .sys_rst_i   (sys_rst_i),
      .wr_en_i     (wr_ser2),
      .wdata_i     (wdata_i[`IPF_COLL_MSB:`IPF_COLL_LSB]),
      .src_i       (serial2_collision_src_i),
      .req_o       (serial2_collision_req_o),
      .req_level_o (serial2_collision_req_level_o),
      .level_o     (serial2_collision_level)
   );

   // [R6] event field
   priority_field u_evt (
      .core_clk_i  (core_clk_i),
      .sys_rst_i   (sys_rst_i),
      .wr_en_i     (wr_ser2),
      .wdata_i     (wdata_i[`IPF_EVT_MSB:`IPF_EVT_LSB]),
      .src_i       (serial2_event_src_i),
      .req_o       (serial2_event_req_o),
      .req_level_o (serial2_event_req_level_o),
      .level_o     (serial2_event_level)
   );

   // ---------------------------------------------------------------
   // read back
   // ---------------------------------------------------------------
   interrupt_priority_fields_pkg::data_t ct5_word;
   interrupt_priority_fields_pkg::data_t ser2_word;
   interrupt_priority_fields_pkg::data_t rdata_d;

   // [R4] unused bits zero
   assign ct5_word  = {9'h000, capture_timer5_level, 4'h0};
   assign ser2_word = {5'h00, serial2_collision_level, 1'b0, serial2_event_level, 4'h0};

   always_comb begin
      if (!rd_i) begin
         rdata_d = 16'h0000;
      end else if (sel == interrupt_priority_fields_pkg::SEL_CT5) begin
         rdata_d = ct5_word;
      end else if (sel == interrupt_priority_fields_pkg::SEL_SER2) begin
         rdata_d = ser2_word;
      end else begin
         rdata_d = 16'h0000;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         rdata_o                   <= 16'h0000;
         capture_timer5_level_o    <= `IPF_LEVEL_RESET;
         serial2_collision_level_o <= `IPF_LEVEL_RESET;
         serial2_event_level_o     <= `IPF_LEVEL_RESET;
      end else begin
         rdata_o                   <= rdata_d;
         capture_timer5_level_o    <= capture_timer5_level;
         serial2_collision_level_o <= serial2_collision_level;
         serial2_event_level_o     <= serial2_event_level;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   unused_zero_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R4]
      $past(rd_i) |-> ((rdata_o & ~`IPF_SER2_MASK) == 16'h0000
                       && ($past(addr_i) != `IPF_CT5_PRIO_ADDR || (rdata_o & ~`IPF_CT5_MASK) == 16'h0000)))
      else $error("unused bit read as one");

   timer_field_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R5]
      (wr_i && addr_i == `IPF_CT5_PRIO_ADDR) ##1 (rd_i && addr_i == `IPF_CT5_PRIO_ADDR && !wr_i)
      |=> rdata_o == ($past(wdata_i, 2) & `IPF_CT5_MASK))
      else $error("timer five field misplaced");

   serial_fields_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R6]
      (wr_i && addr_i == `IPF_SER2_PRIO_ADDR) ##1 (rd_i && addr_i == `IPF_SER2_PRIO_ADDR && !wr_i)
      |=> rdata_o == ($past(wdata_i, 2) & `IPF_SER2_MASK))
      else $error("serial fields misplaced");

   reset_read_a: assert property (@(posedge core_clk_i) // [R7]
      $fell(sys_rst_i) ##0 (rd_i && addr_i == `IPF_SER2_PRIO_ADDR && !wr_i)
      |=> rdata_o == 16'h0440)
      else $error("serial word not at reset value");

   cross_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R8]
      (wr_i && addr_i == `IPF_CT5_PRIO_ADDR) |=> serial2_collision_level == $past(serial2_collision_level))
      else $error("write to timer word changed serial field");

   // ---------------------------------------------------------------
   // field, read and request checks
   // ---------------------------------------------------------------
   timer_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R5]
      wr_ct5 |=> capture_timer5_level == $past(wdata_i[`IPF_CT5_MSB:`IPF_CT5_LSB]))
      else $error("timer five field not loaded from its bits");

   collision_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R6]
      wr_ser2 |=> serial2_collision_level == $past(wdata_i[`IPF_COLL_MSB:`IPF_COLL_LSB]))
      else $error("collision field not loaded from its bits");

   event_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R6]
      wr_ser2 |=> serial2_event_level == $past(wdata_i[`IPF_EVT_MSB:`IPF_EVT_LSB]))
      else $error("event field not loaded from its bits");

   unmapped_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R8]
      (wr_i && sel == interrupt_priority_fields_pkg::SEL_NONE)
      |=> (capture_timer5_level == $past(capture_timer5_level)
           && serial2_collision_level == $past(serial2_collision_level)
           && serial2_event_level == $past(serial2_event_level)))
      else $error("unmapped write changed a field");

   unmapped_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R4]
      (rd_i && sel == interrupt_priority_fields_pkg::SEL_NONE) |=> rdata_o == 16'h0000)
      else $error("unmapped address read as nonzero");

   read_idle_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R4]
      !rd_i |=> rdata_o == 16'h0000)
      else $error("read data nonzero without a read");

   timer_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R5]
      (rd_i && sel == interrupt_priority_fields_pkg::SEL_CT5)
      |=> rdata_o[`IPF_CT5_MSB:`IPF_CT5_LSB] == $past(capture_timer5_level))
      else $error("timer five field read from wrong bits");

   serial_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R6]
      (rd_i && sel == interrupt_priority_fields_pkg::SEL_SER2)
      |=> (rdata_o[`IPF_COLL_MSB:`IPF_COLL_LSB] == $past(serial2_collision_level)
           && rdata_o[`IPF_EVT_MSB:`IPF_EVT_LSB] == $past(serial2_event_level)))
      else $error("serial fields read from wrong bits");

   level_copy_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R7]
      capture_timer5_level_o == $past(capture_timer5_level)
      && serial2_collision_level_o == $past(serial2_collision_level)
      && serial2_event_level_o == $past(serial2_event_level))
      else $error("level output not a copy of its field");

   timer_quiet_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R3]
      (capture_timer5_level == `IPF_LEVEL_OFF)
      |=> (!capture_timer5_req_o && capture_timer5_req_level_o == `IPF_LEVEL_OFF))
      else $error("disabled timer five source raised a request");

   collision_quiet_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R3]
      (serial2_collision_level == `IPF_LEVEL_OFF)
      |=> (!serial2_collision_req_o && serial2_collision_req_level_o == `IPF_LEVEL_OFF))
      else $error("disabled collision source raised a request");

   event_quiet_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R3]
      (serial2_event_level == `IPF_LEVEL_OFF)
      |=> (!serial2_event_req_o && serial2_event_req_level_o == `IPF_LEVEL_OFF))
      else $error("disabled event source raised a request");

   event_top_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R1]
      (serial2_event_src_i && serial2_event_level == `IPF_LEVEL_HIGH)
      |=> (serial2_event_req_o && serial2_event_req_level_o == `IPF_LEVEL_HIGH))
      else $error("event code seven not level seven");

   timer_low_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R2]
      (capture_timer5_src_i && capture_timer5_level == `IPF_LEVEL_LOW)
      |=> (capture_timer5_req_o && capture_timer5_req_level_o == `IPF_LEVEL_LOW))
      else $error("timer five code one not level one");

endmodule // interrupt_priority_fields

// File: interrupt_priority_fields_defines.svh
// constants for the interrupt priority field registers
`ifndef INTERRUPT_PRIORITY_FIELDS_DEFINES_SVH
`define INTERRUPT_PRIORITY_FIELDS_DEFINES_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define IPF_ADDR_W          8
`define IPF_DATA_W          16
`define IPF_CT5_PRIO_ADDR   8'h00
`define IPF_SER2_PRIO_ADDR  8'h04

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define IPF_LEVEL_W         3
`define IPF_CT5_LSB         4
`define IPF_CT5_MSB         6
`define IPF_COLL_LSB        8
`define IPF_COLL_MSB        10
`define IPF_EVT_LSB         4
`define IPF_EVT_MSB         6

// ---------------------------------------------------------------
// reset and level codes, read masks
// ---------------------------------------------------------------
`define IPF_LEVEL_RESET     3'h4
`define IPF_LEVEL_OFF       3'h0
`define IPF_LEVEL_LOW       3'h1
`define IPF_LEVEL_HIGH      3'h7
`define IPF_CT5_MASK        16'h0070
`define IPF_SER2_MASK       16'h0770

`endif

// File: interrupt_priority_fields_pkg.sv
// types for the interrupt priority field registers
package interrupt_priority_fields_pkg;
   typedef logic [2:0]  level_t;
   typedef logic [15:0] data_t;
   typedef logic [7:0]  addr_t;
   // one-hot register select
   typedef enum logic [2:0] {
      SEL_NONE = 3'b001,
      SEL_CT5  = 3'b010,
      SEL_SER2 = 3'b100
   } reg_sel_t;
endpackage

// File: interrupt_priority_fields_test.sv
// self-checking testbench for the interrupt priority field registers
`timescale 1ns/1ps
`include "interrupt_priority_fields_defines.svh"

module interrupt_priority_fields_test;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic                                  core_clk = 1'b0;
   logic                                  sys_rst  = 1'b1;
   interrupt_priority_fields_pkg::addr_t  addr     = 8'h00;
   interrupt_priority_fields_pkg::data_t  wdata    = 16'h0000;
   logic                                  wr       = 1'b0;
   logic                                  rd       = 1'b0;
   logic [2:0]                            src      = 3'h0;
   interrupt_priority_fields_pkg::data_t  rdata;
   logic [2:0]                            req;
   interrupt_priority_fields_pkg::level_t req_lvl [3];
   interrupt_priority_fields_pkg::level_t lvl [3];
   int                                    fail_count      = 0;
   int                                    samples_checked = 0;
   int                                    cycles          = 0;
   logic [2:0]                            c;
   logic [2:0]                            e;

   always #2.5 core_clk = ~core_clk;

   interrupt_priority_fields i_interrupt_priority_fields (
      .core_clk_i                    (core_clk),
      .sys_rst_i                     (sys_rst),
      .addr_i                        (addr),
      .wdata_i                       (wdata),
      .wr_i                          (wr),
      .rd_i                          (rd),
      .rdata_o                       (rdata),
      .capture_timer5_src_i          (src[0]),
      .serial2_collision_src_i       (src[1]),
      .serial2_event_src_i           (src[2]),
      .capture_timer5_req_o          (req[0]),
      .capture_timer5_req_level_o    (req_lvl[0]),
      .serial2_collision_req_o       (req[1]),
      .serial2_collision_req_level_o (req_lvl[1]),
      .serial2_event_req_o           (req[2]),
      .serial2_event_req_level_o     (req_lvl[2]),
      .capture_timer5_level_o        (lvl[0]),
      .serial2_collision_level_o     (lvl[1]),
      .serial2_event_level_o         (lvl[2])
   );

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge core_clk);
      wr    <= 1'b0;
   endtask

   task automatic bus_read(input logic [7:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge core_clk);
      rd   <= 1'b0;
      #1;
      check("read data", rdata, exp);
   endtask

   task automatic bus_write_read(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
      @(posedge core_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge core_clk);
      wr    <= 1'b0;
      rd    <= 1'b1;
      @(posedge core_clk);
      rd    <= 1'b0;
      #1;
      check("read after write", rdata, exp);
   endtask

   task automatic check_src(input int i, input logic [2:0] code, input logic on);
      check("request", {15'h0000, req[i]}, {15'h0000, on && (code != 3'h0)});
      check("request level", {13'h0000, req_lvl[i]}, (on && code != 3'h0) ? {13'h0000, code} : 16'h0000);
      check("field copy", {13'h0000, lvl[i]}, {13'h0000, code});
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // timeout
   // ------------------------------------------------------------
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         summarize();
      end
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      src     <= 3'h7;
      addr    <= `IPF_SER2_PRIO_ADDR;
      rd      <= 1'b1;
      @(posedge core_clk);
      rd      <= 1'b0;
      #1;
      check("first read data", rdata, 16'h0440);
      bus_read(`IPF_CT5_PRIO_ADDR, 16'h0040);
      bus_read(`IPF_SER2_PRIO_ADDR, 16'h0440);
      for (int i = 0; i < 3; i++) check_src(i, 3'h4, 1'b1);
      $display("test reset values done");
      bus_write(`IPF_CT5_PRIO_ADDR, 16'hffff);
      bus_write(`IPF_SER2_PRIO_ADDR, 16'hffff);
      bus_read(`IPF_CT5_PRIO_ADDR, 16'h0070);
      bus_read(`IPF_SER2_PRIO_ADDR, 16'h0770);
      bus_write(`IPF_CT5_PRIO_ADDR, 16'hff8f);
      bus_write(`IPF_SER2_PRIO_ADDR, 16'hf88f);
      bus_read(`IPF_CT5_PRIO_ADDR, 16'h0000);
      bus_read(`IPF_SER2_PRIO_ADDR, 16'h0000);
      $display("test unused bits done");
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         e = 3'h7 - c;
         bus_write_read(`IPF_CT5_PRIO_ADDR, 16'hff8f | {9'h000, c, 4'h0}, {9'h000, c, 4'h0});
         bus_write_read(`IPF_SER2_PRIO_ADDR, 16'hf88f | {5'h00, c, 1'b0, e, 4'h0}, {5'h00, c, 1'b0, e, 4'h0});
         @(posedge core_clk);
         #1;
         check_src(0, c, 1'b1);
         check_src(1, c, 1'b1);
         check_src(2, e, 1'b1);
         bus_read(`IPF_CT5_PRIO_ADDR, {9'h000, c, 4'h0});
         bus_read(`IPF_SER2_PRIO_ADDR, {5'h00, c, 1'b0, e, 4'h0});
      end
      $display("test level codes done");
      @(posedge core_clk);
      src <= 3'h0;
      @(posedge core_clk);
      #1;
      check_src(0, 3'h7, 1'b0);
      check_src(1, 3'h7, 1'b0);
      check_src(2, 3'h0, 1'b0);
      $display("test request release done");
      bus_write(8'h08, 16'hffff);
      bus_read(8'h08, 16'h0000);
      bus_read(`IPF_CT5_PRIO_ADDR, 16'h0070);
      bus_read(`IPF_SER2_PRIO_ADDR, 16'h0700);
      $display("test unmapped address done");
      summarize();
   end
endmodule // interrupt_priority_fields_test

// File: priority_field.sv
// one 3-bit priority field with its gated request
`timescale 1ns/1ps
`include "interrupt_priority_fields_defines.svh"

module priority_field (
   input  wire logic                                   core_clk_i,
   input  wire logic                                   sys_rst_i,
   input  wire logic                                   wr_en_i,
   input  wire interrupt_priority_fields_pkg::level_t  wdata_i,
   input  wire logic                                   src_i,
   output logic                                        req_o,
   output interrupt_priority_fields_pkg::level_t       req_level_o,
   output interrupt_priority_fields_pkg::level_t       level_o
);

   // ---------------------------------------------------------------
   // stored level
   // ---------------------------------------------------------------
   interrupt_priority_fields_pkg::level_t level_q;
   interrupt_priority_fields_pkg::level_t level_d;
   logic                                  active;
   logic                                  req_d;

   // [R8] field bits only
   assign level_d = wr_en_i ? wdata_i : level_q;
   // [R3] zero disables source
   assign active  = (level_q != `IPF_LEVEL_OFF);
   assign req_d   = src_i & active;

   // [R7] reset to level four
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         level_q     <= `IPF_LEVEL_RESET;
         req_o       <= 1'b0;
         req_level_o <= `IPF_LEVEL_OFF;
      end else begin
         level_q     <= level_d;
         req_o       <= req_d;
         // [R1] [R2] code is level
         req_level_o <= req_d ? level_q : `IPF_LEVEL_OFF;
      end
   end

   assign level_o = level_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   reset_level_a: assert property (@(posedge core_clk_i) // [R7]
      $fell(sys_rst_i) |-> level_o == `IPF_LEVEL_RESET)
      else $error("level not four after reset");

   disabled_quiet_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R3]
      (level_o == `IPF_LEVEL_OFF) |=> !req_o)
      else $error("request raised by disabled source");

   top_level_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R1]
      (src_i && level_o == `IPF_LEVEL_HIGH) |=> (req_o && req_level_o == `IPF_LEVEL_HIGH))
      else $error("all-ones code not level seven");

   low_level_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R2]
      (src_i && level_o != `IPF_LEVEL_OFF) |=> (req_o && req_level_o == $past(level_o)))
      else $error("request level does not follow code");

   write_keep_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R8]
      wr_en_i |=> level_o == $past(wdata_i) ##1 (level_o == $past(level_o) || $past(wr_en_i)))
      else $error("field not updated by write");

endmodule // priority_field
